// ===== design/spe_defs.vh
// Constants for the setup parameter editor: register map, field layout, timing
`ifndef SPE_DEFS_VH
`define SPE_DEFS_VH

// Register word addresses (16-bit register numbers)
`define SPE_ADDR_COMMIT      16'h6006
`define SPE_ADDR_RESTART     16'h6008
`define SPE_ADDR_TEST_LO     16'h6ff0
`define SPE_ADDR_TEST_HI     16'h6ffe
`define SPE_ADDR_STATUS      16'h6ff8
`define SPE_HOLD_BASE        16'h6000
`define SPE_INPUT_BASE       16'h4000
`define SPE_FAST_BASE        16'h5000
`define SPE_GROUP_MASS       4'h9
`define SPE_GROUP_HMI        4'hf
`define SPE_FAST_COMBINED    4'h0
`define SPE_FAST_TEMP        4'h1
`define SPE_FAST_TOTAL       4'h2

// Trigger value for commit and restart
`define SPE_TRIGGER_VAL      32'h0000_0001

// Reset values
`define SPE_TEST_RESET       32'h0000_0000
`define SPE_IDLE_RESET       16'h003c

// Timing
`define SPE_SAVE_MAX_MS      1000
`define SPE_RESTART_MAX_MS   1000
`define SPE_CLK_MHZ          50
`define SPE_RESTART_CYCLES   16'h0010
`define SPE_TICK_CYCLES      32'd50000

// Editor field layout
`define SPE_DIGITS           8
`define SPE_POS_SIGN         4'h0
`define SPE_POS_POINT        4'h9

`endif

// ===== design/spe_digit_edit.v
// Digit entry engine: one value edited digit by digit from the front panel
`timescale 1ns/100ps

module spe_digit_edit
#(
   parameter NDIG = 8
)
(
   input  wire              clk,
   input  wire              rst,
   input  wire              load,
   input  wire [4*NDIG-1:0] load_val,
   input  wire              hex_mode,
   input  wire [4*NDIG-1:0] lim_hi,
   input  wire              advance,
   input  wire              select,
   output reg  [4*NDIG-1:0] val_r,
   output reg               neg_r,
   output reg  [3:0]        point_r,
   output reg  [3:0]        pos_r,
   output reg               done_r,
   output wire              out_range
);

   // ---------------------------------------------
   // Range check
   // ---------------------------------------------
   // Negative values are never out of range against an upper limit
   assign out_range = !neg_r && (val_r > lim_hi);

   // Wrap a nibble: 9 for decimal, F for passcode hex entry
   function [3:0] spe_inc_digit;
      input [3:0] d;
      input       hx;
      begin
         if (!hx && d == 4'h9)
            spe_inc_digit = 4'h0;
         else
            spe_inc_digit = d + 4'h1;
      end
   endfunction

   integer i;

   // ---------------------------------------------
   // Cursor and value state
   // ---------------------------------------------
   // Positions: 0 sign, 1..NDIG digits, NDIG+1 decimal point
   always @(posedge clk)
   begin
      if (rst)
      begin
         val_r   <= {4*NDIG{1'b0}};
         neg_r   <= 1'b0;
         point_r <= 4'h0;
         pos_r   <= 4'h0;
         done_r  <= 1'b0;
      end
      else if (load)
      begin
         val_r   <= load_val;
         neg_r   <= 1'b0;
         point_r <= 4'h0;
         pos_r   <= 4'h0;
         done_r  <= 1'b0;
      end
      else if (done_r)
      begin
         if (advance)
         begin
            done_r <= 1'b0;
            pos_r  <= 4'h0;
         end
      end
      else if (advance)
      begin
         if (pos_r == 4'h0)
            neg_r <= ~neg_r;
         else if (pos_r == NDIG + 1)
         begin
            // Point moves right while the cursor stays on the point position; stops at last digit
            if (point_r < NDIG - 1)
               point_r <= point_r + 4'h1;
         end
         else
         begin
            for (i = 0; i < NDIG; i = i + 1)
               if (pos_r == i + 1)
                  val_r[4*(NDIG-1-i) +: 4] <=
                     spe_inc_digit(val_r[4*(NDIG-1-i) +: 4], hex_mode);
         end
      end
      else if (select)
      begin
         if (pos_r == NDIG + 1)
         begin
            if (out_range)
               pos_r <= 4'h0;
            else
               done_r <= 1'b1;
         end
         else
            pos_r <= pos_r + 4'h1;
      end
   end

endmodule // spe_digit_edit

// ===== design/spe_param_editor.v
// Setup parameter editor: register write path, commit/restart, front-panel menu
// Notes on behaviour
// - Holding writes go to shadow set only
// - Commit 1 saves shadow; active after reset
// - Save finishes within one second; master waits
// - Restart 1 forces full reset within second
// - Test registers act now, never saved
// - Decode functional groups by base address
// - Three fast-access ranges mirror other registers
// - Back in menu goes to parent level
// - Back in entry leaves without accepting
// - Advance increments digit, wraps 9 or F
// - Advance on sign toggles plus/minus
// - Advance on point moves it right
// - Advance at end returns to first position
// - Select in menu descends or opens entry
// - Select moves cursor; rightmost valid ends
// - Out of range inverts; select wraps left
// - Select at end accepts, returns to menu
// - Select on bit display increments bit index
// - Panel edits held in panel_val_r, never saved
// - Idle timeout: home screen, login revoked
// - Advance steps items, wraps last to first
`timescale 1ns/100ps
`include "spe_defs.vh"

module spe_param_editor
#(
   parameter NPAR      = 16,
   parameter NDIG      = `SPE_DIGITS,
   parameter SAVE_CYC  = 32'd1000,
   parameter TICK_CYC  = `SPE_TICK_CYCLES,
   parameter NITEMS    = 4,
   parameter NLEVELS   = 3
)
(
   input  wire        MCLK,
   input  wire        SRST,
   input  wire        REG_WR,
   input  wire        REG_RD,
   input  wire [15:0] REG_ADDR,
   input  wire [31:0] REG_WDATA,
   output reg  [31:0] REG_RDATA,
   output reg         REG_ACK,
   output reg         REG_ERR,
   output wire        NVM_WR,
   output wire [3:0]  NVM_ADDR,
   output wire [31:0] NVM_WDATA,
   output reg         SYS_RESET_REQ,
   output reg  [31:0] TEST_PARAM,
   input  wire        BACK_BUTTON,
   input  wire        ADVANCE_BUTTON,
   input  wire        SELECT_BUTTON,
   output reg  [2:0]  MENU_STATE,
   output reg  [1:0]  MENU_LEVEL,
   output reg  [3:0]  MENU_ITEM,
   output reg  [4:0]  BIT_INDEX,
   output wire [4*`SPE_DIGITS-1:0] EDIT_VALUE,
   output wire [3:0]  EDIT_POS,
   output wire        EDIT_INVERT,
   output reg         LOGIN_ACTIVE,
   output reg  [2:0]  HOME_SCREEN_CHOICE
);

   // ------------------------------------------------
   // Menu states
   // ------------------------------------------------
   localparam ST_HOME  = 3'd0;
   localparam ST_MENU  = 3'd1;
   localparam ST_EDIT  = 3'd2;
   localparam ST_BITS  = 3'd3;

   // ------------------------------------------------
   // Button synchronisers and press detection
   // ------------------------------------------------
   reg  [2:0] btn_s1_r;
   reg  [2:0] btn_s2_r;
   reg  [2:0] btn_d_r;
   wire [2:0] press = btn_s2_r & ~btn_d_r;

   // Two flops before anything looks at the panel pins
   always @(posedge MCLK)
   begin
      if (SRST)
      begin
         btn_s1_r <= 3'b000;
         btn_s2_r <= 3'b000;
         btn_d_r  <= 3'b000;
      end
      else
      begin
         btn_s1_r <= {SELECT_BUTTON, ADVANCE_BUTTON, BACK_BUTTON};
         btn_s2_r <= btn_s1_r;
         btn_d_r  <= btn_s2_r;
      end
   end

   wire back_p = press[0];
   wire adv_p  = press[1];
   wire sel_p  = press[2];

   // ------------------------------------------------
   // Address decode
   // ------------------------------------------------
   function spe_is_shadow;
      input [15:0] a;
      begin
         spe_is_shadow = (a[15:12] == `SPE_HOLD_BASE >> 12) && (a[11:8] != 4'h1)
                         && (a < `SPE_ADDR_TEST_LO);
      end
   endfunction

   function spe_is_readable;
      input [15:0] a;
      begin
         // Input range, fast range and shadow addresses read the stored set by low bits
         spe_is_readable = (a[15:12] == `SPE_INPUT_BASE >> 12) ||
                           ((a[15:12] == `SPE_FAST_BASE >> 12) && (a[11:8] <= `SPE_FAST_TOTAL)) ||
                           spe_is_shadow(a);
      end
   endfunction

   // ------------------------------------------------
   // Shadow set and stored set
   // ------------------------------------------------
   reg [31:0] shadow_r [0:NPAR-1];
   reg [31:0] stored_r [0:NPAR-1];
   reg [3:0]  save_idx_r;
   reg        saving_r;
   reg [31:0] save_cnt_r;
   reg [15:0] rst_cnt_r;
   reg        rst_pend_r;
   reg [15:0] idle_time_r;
   integer    k;

   wire [3:0] sidx    = REG_ADDR[4:1];
   wire       wr_shad = REG_WR && spe_is_shadow(REG_ADDR) && !saving_r;
   wire       wr_test = REG_WR && REG_ADDR >= `SPE_ADDR_TEST_LO &&
                        REG_ADDR <= `SPE_ADDR_TEST_HI;

   // Writes land in the shadow copy only; stored set is untouched
   always @(posedge MCLK)
   begin
      if (SRST)
      begin
         for (k = 0; k < NPAR; k = k + 1)
            shadow_r[k] <= stored_r[k];
      end
      else if (wr_shad)
         shadow_r[sidx] <= REG_WDATA;
   end

   // Non-volatile image: only the commit sequence writes it; keeps value over reset
   always @(posedge MCLK)
   begin
      if (saving_r)
         stored_r[save_idx_r] <= shadow_r[save_idx_r];
   end

   assign NVM_WR    = saving_r;
   assign NVM_ADDR  = save_idx_r;
   assign NVM_WDATA = shadow_r[save_idx_r];

   // Commit sequencer: one word per cycle, bounded far below a second
   always @(posedge MCLK)
   begin
      if (SRST)
      begin
         saving_r   <= 1'b0;
         save_idx_r <= 4'h0;
         save_cnt_r <= 32'h0;
      end
      else if (!saving_r)
      begin
         if (REG_WR && REG_ADDR == `SPE_ADDR_COMMIT && REG_WDATA == `SPE_TRIGGER_VAL)
         begin
            saving_r   <= 1'b1;
            save_idx_r <= 4'h0;
            save_cnt_r <= 32'h0;
         end
      end
      else
      begin
         save_cnt_r <= save_cnt_r + 32'h1;
         if (save_idx_r == NPAR - 1 || save_cnt_r >= SAVE_CYC)
            saving_r <= 1'b0;
         else
            save_idx_r <= save_idx_r + 4'h1;
      end
   end

   // Restart request: pulse held a fixed count, well under one second
   always @(posedge MCLK)
   begin
      if (SRST)
      begin
         rst_pend_r    <= 1'b0;
         rst_cnt_r     <= 16'h0;
         SYS_RESET_REQ <= 1'b0;
      end
      else if (REG_WR && REG_ADDR == `SPE_ADDR_RESTART && REG_WDATA == `SPE_TRIGGER_VAL)
      begin
         rst_pend_r    <= 1'b1;
         rst_cnt_r     <= `SPE_RESTART_CYCLES;
         SYS_RESET_REQ <= 1'b1;
      end
      else if (rst_pend_r)
      begin
         rst_cnt_r <= rst_cnt_r - 16'h1;
         if (rst_cnt_r == 16'h1)
         begin
            rst_pend_r    <= 1'b0;
            SYS_RESET_REQ <= 1'b0;
         end
      end
   end

   // Test register: live at once, default after every reset, never saved
   always @(posedge MCLK)
   begin
      if (SRST)
         TEST_PARAM <= `SPE_TEST_RESET;
      else if (wr_test)
         TEST_PARAM <= REG_WDATA;
   end

   // Bus answer one cycle after the request; unmapped reads flag an error
   always @(posedge MCLK)
   begin
      if (SRST)
      begin
         REG_ACK   <= 1'b0;
         REG_ERR   <= 1'b0;
         REG_RDATA <= 32'h0;
      end
      else
      begin
         REG_ACK <= REG_WR || REG_RD;
         REG_ERR <= 1'b0;
         if (REG_RD)
         begin
            if (REG_ADDR == `SPE_ADDR_STATUS)
               REG_RDATA <= {29'h0, rst_pend_r, saving_r, LOGIN_ACTIVE};
            else if (REG_ADDR >= `SPE_ADDR_TEST_LO && REG_ADDR <= `SPE_ADDR_TEST_HI)
               REG_RDATA <= TEST_PARAM;
            else if (spe_is_readable(REG_ADDR))
               REG_RDATA <= stored_r[sidx];
            else
            begin
               REG_RDATA <= 32'h0;
               REG_ERR   <= 1'b1;
            end
         end
         else if (REG_WR && !spe_is_shadow(REG_ADDR) && !wr_test &&
                  REG_ADDR != `SPE_ADDR_COMMIT && REG_ADDR != `SPE_ADDR_RESTART)
            REG_ERR <= 1'b1;
      end
   end

   // ------------------------------------------------
   // Front-panel editor
   // ------------------------------------------------
   wire        edit_done;
   wire        edit_load = (MENU_STATE == ST_MENU) && sel_p && (MENU_LEVEL == NLEVELS - 1)
                           && (MENU_ITEM != NITEMS - 1);
   // Edited values stay in panel_val_r only; nothing writes them to the shadow
   reg  [31:0] panel_val_r;

   spe_digit_edit #(.NDIG(NDIG)) u_edit
   (
      .clk       (MCLK),
      .rst       (SRST),
      .load      (edit_load),
      .load_val  (stored_r[MENU_ITEM]),
      .hex_mode  (MENU_ITEM == 4'h0),
      .lim_hi    (32'h9999_9999),
      .advance   (adv_p && MENU_STATE == ST_EDIT),
      .select    (sel_p && MENU_STATE == ST_EDIT),
      .val_r     (EDIT_VALUE),
      .neg_r     (),
      .point_r   (),
      .pos_r     (EDIT_POS),
      .done_r    (edit_done),
      .out_range (EDIT_INVERT)
   );

   reg [31:0] idle_cnt_r;
   reg [15:0] idle_sec_r;

   // Idle timer counts in milliseconds, any press restarts it
   always @(posedge MCLK)
   begin
      if (SRST || |press)
      begin
         idle_cnt_r <= 32'h0;
         idle_sec_r <= 16'h0;
      end
      else if (idle_cnt_r >= TICK_CYC - 1)
      begin
         idle_cnt_r <= 32'h0;
         idle_sec_r <= idle_sec_r + 16'h1;
      end
      else
         idle_cnt_r <= idle_cnt_r + 32'h1;
   end

   // Menu state machine
   always @(posedge MCLK)
   begin
      if (SRST)
      begin
         MENU_STATE         <= ST_HOME;
         MENU_LEVEL         <= 2'd0;
         MENU_ITEM          <= 4'h0;
         BIT_INDEX          <= 5'd0;
         LOGIN_ACTIVE       <= 1'b0;
         HOME_SCREEN_CHOICE <= 3'd0;
         panel_val_r        <= 32'h0;
         idle_time_r        <= `SPE_IDLE_RESET;
      end
      else if (idle_sec_r >= idle_time_r && idle_time_r != 16'h0 && !(|press))
      begin
         MENU_STATE   <= ST_HOME;
         MENU_LEVEL   <= 2'd0;
         LOGIN_ACTIVE <= 1'b0;
      end
      else
      begin
         case (MENU_STATE)
            ST_HOME:
               if (sel_p)
               begin
                  MENU_STATE <= ST_MENU;
                  MENU_ITEM  <= 4'h0;
               end
               else if (adv_p)
                  HOME_SCREEN_CHOICE <= HOME_SCREEN_CHOICE + 3'd1;
            ST_MENU:
               if (back_p)
               begin
                  MENU_ITEM <= 4'h0;
                  if (MENU_LEVEL == 2'd0)
                     MENU_STATE <= ST_HOME;
                  else
                     MENU_LEVEL <= MENU_LEVEL - 2'd1;
               end
               else if (adv_p)
                  MENU_ITEM <= (MENU_ITEM == NITEMS - 1) ? 4'h0 : MENU_ITEM + 4'h1;
               else if (sel_p)
               begin
                  if (MENU_LEVEL != NLEVELS - 1)
                  begin
                     MENU_LEVEL   <= MENU_LEVEL + 2'd1;
                     MENU_ITEM    <= 4'h0;
                     LOGIN_ACTIVE <= LOGIN_ACTIVE | (MENU_LEVEL == 2'd0);
                  end
                  else if (MENU_ITEM == NITEMS - 1)
                  begin
                     MENU_STATE <= ST_BITS;
                     BIT_INDEX  <= 5'd0;
                  end
                  else
                     MENU_STATE <= ST_EDIT;
               end
            ST_EDIT:
               if (back_p)
                  MENU_STATE <= ST_MENU;
               else if (sel_p && edit_done)
               begin
                  panel_val_r <= EDIT_VALUE;
                  MENU_STATE  <= ST_MENU;
               end
            ST_BITS:
               if (back_p)
                  MENU_STATE <= ST_MENU;
               else if (sel_p)
                  BIT_INDEX <= BIT_INDEX + 5'd1;
            default:
               MENU_STATE <= ST_HOME;
         endcase
      end
   end

endmodule // spe_param_editor

// ===== tb/spe_checker_sva.sv
// Checker: register bus, save, restart and test register properties
`timescale 1ns/100ps
module spe_checker
(
   input logic        MCLK,
   input logic        SRST,
   input logic        REG_WR,
   input logic        REG_RD,
   input logic [15:0] REG_ADDR,
   input logic [31:0] REG_WDATA,
   input logic        REG_ACK,
   input logic        REG_ERR,
   input logic        NVM_WR,
   input logic [3:0]  NVM_ADDR,
   input logic        SYS_RESET_REQ,
   input logic [31:0] TEST_PARAM,
   input logic [2:0]  MENU_STATE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   //--------------------------------------------------------------
   // Register bus
   //--------------------------------------------------------------
   // Every request gets its answer one cycle later
   property p_ack; (REG_WR || REG_RD) |=> REG_ACK; endproperty
   a_ack: assert property (p_ack) else $error("missing ack");
   property p_err; REG_RD && REG_ADDR < 16'h4000 |=> REG_ACK && REG_ERR; endproperty
   a_err: assert property (p_err) else $error("unmapped read not flagged");
   //--------------------------------------------------------------
   // Commit and restart triggers
   //--------------------------------------------------------------
   // A commit while saving is ignored, hence the idle guard
   property p_commit;
      REG_WR && REG_ADDR == 16'h6006 && REG_WDATA == 32'h1 && !NVM_WR
      |=> NVM_WR && NVM_ADDR == 4'h0;
   endproperty
   a_commit: assert property (p_commit) else $error("commit did not start save");
   property p_save; $rose(NVM_WR) |-> ##15 (NVM_WR && NVM_ADDR == 4'hf) ##1 !NVM_WR; endproperty
   a_save: assert property (p_save) else $error("save length wrong");
   property p_commit_ign;
      REG_WR && REG_ADDR == 16'h6006 && REG_WDATA != 32'h1 && !NVM_WR |=> !NVM_WR;
   endproperty
   a_commit_ign: assert property (p_commit_ign) else $error("bad commit acted");
   property p_restart; REG_WR && REG_ADDR == 16'h6008 && REG_WDATA == 32'h1
      |=> SYS_RESET_REQ [*8]; endproperty
   a_restart: assert property (p_restart) else $error("restart not raised");
   property p_restart_len; $rose(SYS_RESET_REQ) |-> ##15 SYS_RESET_REQ ##1 !SYS_RESET_REQ;
   endproperty
   a_restart_len: assert property (p_restart_len) else $error("restart length wrong");
   property p_restart_ign; REG_WR && REG_ADDR == 16'h6008 && REG_WDATA != 32'h1
      && !SYS_RESET_REQ |=> !SYS_RESET_REQ; endproperty
   a_restart_ign: assert property (p_restart_ign) else $error("bad restart acted");
   //--------------------------------------------------------------
   // Live test register and shadow writes
   //--------------------------------------------------------------
   property p_test; REG_WR && REG_ADDR == 16'h6ff0 |=> TEST_PARAM == $past(REG_WDATA);
   endproperty
   a_test: assert property (p_test) else $error("test value not live");
   property p_test_nosave; REG_WR && REG_ADDR == 16'h6ff0 && !NVM_WR |=> !NVM_WR; endproperty
   a_test_nosave: assert property (p_test_nosave) else $error("test write saved");
   property p_shadow; REG_WR && REG_ADDR == 16'h6902 |=> $stable(TEST_PARAM); endproperty
   a_shadow: assert property (p_shadow) else $error("holding write acted");
   c_save: cover property ($rose(NVM_WR));
   c_restart: cover property ($rose(SYS_RESET_REQ));
   c_edit: cover property (MENU_STATE == 3'h2);
   c_bits: cover property (MENU_STATE == 3'h3);
endmodule // spe_checker
bind spe_param_editor spe_checker spe_checker_inst (.MCLK(MCLK), .SRST(SRST),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_ACK(REG_ACK), .REG_ERR(REG_ERR), .NVM_WR(NVM_WR), .NVM_ADDR(NVM_ADDR),
   .SYS_RESET_REQ(SYS_RESET_REQ), .TEST_PARAM(TEST_PARAM), .MENU_STATE(MENU_STATE));

// ===== tb/spe_operator.sv
// Bus master and front-panel operator model driving the editor's inputs
`timescale 1ns/100ps
module spe_operator
(
   input  logic        MCLK,
   input  logic        op_wr,
   input  logic        op_rd,
   input  logic [15:0] op_addr,
   input  logic [31:0] op_wdata,
   input  logic [2:0]  op_keys,
   output logic        REG_WR,
   output logic        REG_RD,
   output logic [15:0] REG_ADDR,
   output logic [31:0] REG_WDATA,
   output logic        BACK_BUTTON,
   output logic        ADVANCE_BUTTON,
   output logic        SELECT_BUTTON
);
   // Requests go out on the next edge; released lines carry the inverse so stale data
   // never matches. Key bits: 0 back, 1 advance, 2 select
   always @(posedge MCLK)
   begin
      REG_WR    <= op_wr;
      REG_RD    <= op_rd;
      REG_ADDR  <= (op_wr || op_rd) ? op_addr : ~op_addr;
      REG_WDATA <= op_wr ? op_wdata : ~op_wdata;
      {SELECT_BUTTON, ADVANCE_BUTTON, BACK_BUTTON} <= op_keys;
   end
endmodule // spe_operator

// ===== tb/spe_param_editor_bench.sv
// Testbench: commit, restart, test register, menu and digit entry
`timescale 1ns/100ps
module spe_param_editor_bench;
   logic        MCLK, SRST, REG_WR, REG_RD, REG_ACK, REG_ERR, NVM_WR, SYS_RESET_REQ;
   logic        BACK_BUTTON, ADVANCE_BUTTON, SELECT_BUTTON, EDIT_INVERT, LOGIN_ACTIVE;
   logic [15:0] REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, NVM_WDATA, TEST_PARAM, EDIT_VALUE;
   logic [3:0]  NVM_ADDR, MENU_ITEM, EDIT_POS;
   logic [2:0]  MENU_STATE, HOME_SCREEN_CHOICE;
   logic [1:0]  MENU_LEVEL;
   logic [4:0]  BIT_INDEX;
   int          error_cnt = 0;
   int          n_compared = 0;
   logic        op_wr = 1'b0, op_rd = 1'b0;
   logic [15:0] op_addr = 16'h0;
   logic [31:0] op_wdata = 32'h0;
   logic [2:0]  op_keys = 3'h0;
   spe_param_editor #(.TICK_CYC(32'd10)) spe_param_editor_inst (.MCLK(MCLK), .SRST(SRST),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR), .NVM_WR(NVM_WR),
      .NVM_ADDR(NVM_ADDR), .NVM_WDATA(NVM_WDATA), .SYS_RESET_REQ(SYS_RESET_REQ),
      .TEST_PARAM(TEST_PARAM), .BACK_BUTTON(BACK_BUTTON), .ADVANCE_BUTTON(ADVANCE_BUTTON),
      .SELECT_BUTTON(SELECT_BUTTON), .MENU_STATE(MENU_STATE), .MENU_LEVEL(MENU_LEVEL),
      .MENU_ITEM(MENU_ITEM), .BIT_INDEX(BIT_INDEX), .EDIT_VALUE(EDIT_VALUE),
      .EDIT_POS(EDIT_POS), .EDIT_INVERT(EDIT_INVERT), .LOGIN_ACTIVE(LOGIN_ACTIVE),
      .HOME_SCREEN_CHOICE(HOME_SCREEN_CHOICE));
   spe_operator op_inst (.MCLK(MCLK), .op_wr(op_wr), .op_rd(op_rd), .op_addr(op_addr),
      .op_wdata(op_wdata), .op_keys(op_keys), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .BACK_BUTTON(BACK_BUTTON),
      .ADVANCE_BUTTON(ADVANCE_BUTTON), .SELECT_BUTTON(SELECT_BUTTON));
   //--------------------------------------------------------------
   // Shared helpers
   //--------------------------------------------------------------
   task automatic final_report();
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A bound that runs out is a mismatch and ends the run
   task automatic give_up(input logic hit);
      if (hit)
      begin
         error_cnt++;
         final_report();
      end
   endtask
   // Register access; the model adds one edge, the answer stands the edge after
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic exp_err);
      @(posedge MCLK);
      op_wr    <= wr;
      op_rd    <= ~wr;
      op_addr  <= a;
      op_wdata <= d;
      @(posedge MCLK);
      op_wr <= 1'b0;
      op_rd <= 1'b0;
      repeat (2) @(posedge MCLK);
      chk(32'(REG_ACK), 32'h1);
      chk(32'(REG_ERR), 32'(exp_err));
      if (!wr && !exp_err)
         chk(REG_RDATA, exp);
   endtask
   // Levels held well past the two-flop synchroniser; 0 back, 1 advance, 2 select
   task automatic press(input logic [1:0] k);
      @(posedge MCLK);
      op_keys <= 3'b001 << k;
      repeat (4) @(posedge MCLK);
      op_keys <= 3'b000;
      repeat (6) @(posedge MCLK);
   endtask
   // Counts cycles a level stays high; the bound keeps the master from hanging
   task automatic count_high(ref logic s, output int n, output logic [31:0] w);
      n = 0;
      while (s && n < 40)
      begin
         if (NVM_ADDR == 4'h1)
            w = NVM_WDATA;
         @(posedge MCLK);
         n++;
      end
      give_up(n >= 40);
   endtask
   //--------------------------------------------------------------
   // Scenarios
   //--------------------------------------------------------------
   task automatic t_commit();
      int          n;
      logic [31:0] w;
      acc(1'b1, 16'h6900, 32'h0000_0000, 32'h0, 1'b0);
      acc(1'b1, 16'h6902, 32'h1234_5678, 32'h0, 1'b0);
      acc(1'b1, 16'h6006, 32'h0000_0002, 32'h0, 1'b0);
      chk(32'(NVM_WR), 32'h0);
      acc(1'b1, 16'h6006, 32'h0000_0001, 32'h0, 1'b0);
      count_high(NVM_WR, n, w);
      chk(32'(n), 32'd16);
      chk(w, 32'h1234_5678);
      acc(1'b1, 16'h6902, 32'ha5a5_a5a5, 32'h0, 1'b0);
      acc(1'b0, 16'h4902, 32'h0, 32'h1234_5678, 1'b0);
      acc(1'b0, 16'h5002, 32'h0, 32'h1234_5678, 1'b0);
      acc(1'b0, 16'h5102, 32'h0, 32'h1234_5678, 1'b0);
      acc(1'b0, 16'h5202, 32'h0, 32'h1234_5678, 1'b0);
      acc(1'b0, 16'h3000, 32'h0, 32'h0, 1'b1);
   endtask
   task automatic t_restart();
      int          n;
      logic [31:0] w;
      acc(1'b1, 16'h6ff0, 32'hc0de_0042, 32'h0, 1'b0);
      chk(TEST_PARAM, 32'hc0de_0042);
      acc(1'b1, 16'h6008, 32'h0000_0000, 32'h0, 1'b0);
      chk(32'(SYS_RESET_REQ), 32'h0);
      acc(1'b1, 16'h6008, 32'h0000_0001, 32'h0, 1'b0);
      count_high(SYS_RESET_REQ, n, w);
      chk(32'(n), 32'd16);
      SRST <= 1'b1;
      repeat (2) @(posedge MCLK);
      SRST <= 1'b0;
      @(posedge MCLK);
      chk(TEST_PARAM, 32'h0);
      acc(1'b0, 16'h4902, 32'h0, 32'h1234_5678, 1'b0);
   endtask
   task automatic t_menu();
      int n;
      press(2'd1);
      chk(32'(HOME_SCREEN_CHOICE), 32'h1);
      press(2'd2);
      chk(32'(MENU_STATE), 32'h1);
      repeat (3) press(2'd1);
      chk(32'(MENU_ITEM), 32'h3);
      press(2'd1);
      chk(32'(MENU_ITEM), 32'h0);
      press(2'd2);
      chk(32'(MENU_LEVEL), 32'h1);
      chk(32'(LOGIN_ACTIVE), 32'h1);
      press(2'd0);
      chk(32'(MENU_LEVEL), 32'h0);
      // Sixty ticks of ten cycles with no press
      n = 0;
      while (MENU_STATE != 3'h0 && n < 700)
      begin
         @(posedge MCLK);
         n++;
      end
      give_up(n >= 700);
      chk(32'(n >= 500 && n < 700), 32'h1);
      chk(32'(LOGIN_ACTIVE), 32'h0);
   endtask
   task automatic t_edit();
      int         n;
      logic [3:0] d;
      logic [4:0] b;
      repeat (4) press(2'd2);
      chk(32'(MENU_STATE), 32'h2);
      n = 0;
      while (EDIT_POS != 4'h1 && n < 10)
      begin
         press(2'd2);
         n++;
      end
      give_up(n >= 10);
      chk(32'(EDIT_POS), 32'h1);
      // Sixteen presses walk the hex digit through its F to 0 wrap
      for (int i = 0; i < 16; i++)
      begin
         d = EDIT_VALUE[31:28];
         press(2'd1);
         chk(32'(EDIT_VALUE[31:28]), 32'(4'(d + 4'h1)));
      end
      repeat (4'ha - EDIT_VALUE[31:28]) press(2'd1);
      chk(32'(EDIT_INVERT), 32'h1);
      press(2'd2);
      chk(32'(EDIT_POS), 32'h2);
      // Out of range at the point position: select wraps to the sign
      repeat (8) press(2'd2);
      chk(32'(EDIT_POS), 32'h0);
      press(2'd1);
      chk(32'(EDIT_INVERT), 32'h0);
      repeat (10) press(2'd2);
      press(2'd1);
      chk(32'(EDIT_POS), 32'h0);
      repeat (11) press(2'd2);
      chk(32'(MENU_STATE), 32'h1);
      acc(1'b0, 16'h4900, 32'h0, 32'h0, 1'b0);
      press(2'd2);
      press(2'd0);
      chk(32'(MENU_STATE), 32'h1);
      repeat (3) press(2'd1);
      press(2'd2);
      chk(32'(MENU_STATE), 32'h3);
      b = BIT_INDEX;
      press(2'd2);
      chk(32'(BIT_INDEX), 32'(5'(b + 5'h01)));
   endtask
   //--------------------------------------------------------------
   // Clock, reset and main sequence
   //--------------------------------------------------------------
   initial
   begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end
   initial
   begin
      SRST = 1'b1;
      repeat (20) @(posedge MCLK);
      SRST <= 1'b0;
      t_commit();
      t_restart();
      t_menu();
      t_edit();
      final_report();
   end
endmodule // spe_param_editor_bench
